// ### acc_analog_comparator_control.sv
// Digital control around the on-chip analog comparator, with AXI4-Lite registers
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module acc_analog_comparator_control (
  input wire logic mclk, // 200 MHz system clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [acc_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [acc_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic compareRaw, // Raw analog comparator output, asynchronous
  input wire logic converterEnable, // Converter enable from converter block
  input wire logic [2:0] channelSelect, // Converter channel select
  input wire logic globalIrqEnable, // Global interrupt enable of the processor
  input wire logic irqVectorAck, // Pulse: comparator vector executed
  input wire logic [1:0] pinRaw, // Digital level of the two comparator pins
  output logic comparatorPowerOff, // Comparator analog power off
  output logic bandgapPositiveSelect, // Positive input from bandgap
  output logic negUseChannel, // Negative input from converter channel mux
  output logic [2:0] negChannel, // Channel used as negative input
  output logic compareResult, // Synchronised comparator result
  output logic compareEventFlag, // Sticky event flag
  output logic irqRequest, // Comparator interrupt request
  output logic captureRouteEnable, // Timer capture source is the comparator
  output logic captureInput, // Comparator result towards capture front end
  output logic [1:0] inputBufferEnable, // Digital input buffer enables
  output logic [1:0] portPinIn // Port input bits of the two pins
);
  import acc_pkg::*;

  logic [7:0] convCtrlB;
  logic [7:0] cmpCtrl;
  logic [7:0] pinDisable;
  logic syncStage1;
  logic prevResult;
  logic [1:0] pinSync1;
  logic [1:0] pinSync2;
  logic [ADDR_W-1:0] awAddrHeld;
  logic awHeld;
  logic [31:0] wDataHeld;
  logic [3:0] wStrbHeld;
  logic wHeld;
  logic doWrite;
  logic wrCmp;
  logic wrLane0;
  logic clearFlagWrite;
  logic eventHit;
  acc_mode_t eventMode;

  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    isMapped = (addr == OFS_CONV_CTRL_B) || (addr == OFS_CMP_CTRL_STATUS) ||
               (addr == OFS_PIN_INPUT_DISABLE);
  endfunction : isMapped

  function automatic logic edgeMatch(input acc_mode_t mode, input logic prev,
                                     input logic cur);
    case (mode)
      ACC_MODE_TOGGLE: edgeMatch = prev != cur; // [R14]
      ACC_MODE_FALLING: edgeMatch = prev && !cur; // [R14]
      ACC_MODE_RISING: edgeMatch = !prev && cur; // [R14]
      default: edgeMatch = 1'b0; // [R14]
    endcase
  endfunction : edgeMatch

  // Analog selection outputs
  assign comparatorPowerOff = cmpCtrl[BIT_POWER_OFF]; // [R4]
  assign bandgapPositiveSelect = cmpCtrl[BIT_BANDGAP_SEL]; // [R6]
  assign negUseChannel = convCtrlB[BIT_MUX_NEG_EN] && !converterEnable; // [R2] [R3]
  assign negChannel = negUseChannel ? channelSelect : 3'h0; // [R2]
  assign eventMode = acc_mode_t'(cmpCtrl[BIT_MODE_LO +: 2]);
  assign captureRouteEnable = cmpCtrl[BIT_CAPTURE_ROUTE];

  // Raw output feeds the first flop directly; power-off clears both stages so it reads low
  always_ff @(posedge mclk) begin
    if (!reset_n || cmpCtrl[BIT_POWER_OFF]) begin
      syncStage1 <= 1'b0; // [R1] [R4]
      compareResult <= 1'b0; // [R1] [R4]
    end else begin
      syncStage1 <= compareRaw; // [R7]
      compareResult <= syncStage1; // [R7]
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prevResult <= 1'b0;
    end else begin
      prevResult <= compareResult; // [R20]
    end
  end

  assign eventHit = edgeMatch(eventMode, prevResult, compareResult); // [R8] [R20]

  // Write path: address and data are taken in either order
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign doWrite = awHeld && wHeld;
  assign wrLane0 = doWrite && wStrbHeld[0];
  assign wrCmp = wrLane0 && (awAddrHeld == OFS_CMP_CTRL_STATUS);
  assign clearFlagWrite = wrCmp && wDataHeld[BIT_EVENT_FLAG]; // [R11]

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      awHeld <= 1'b0;
      awAddrHeld <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddrHeld <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wHeld <= 1'b0;
      wDataHeld <= 32'h0000_0000;
      wStrbHeld <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wDataHeld <= s_axi_wdata;
      wStrbHeld <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= isMapped(awAddrHeld) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; result and flag bits are not stored from the bus
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      convCtrlB <= RST_CONV_CTRL_B;
      pinDisable <= RST_PIN_INPUT_DISABLE;
      cmpCtrl <= RST_CMP_CTRL_STATUS;
    end else if (wrLane0) begin
      if (awAddrHeld == OFS_CONV_CTRL_B) begin
        convCtrlB[BIT_MUX_NEG_EN] <= wDataHeld[BIT_MUX_NEG_EN];
      end
      if (awAddrHeld == OFS_PIN_INPUT_DISABLE) begin
        pinDisable[1:0] <= wDataHeld[1:0]; // [R16]
      end
      if (wrCmp) begin
        cmpCtrl[BIT_POWER_OFF] <= wDataHeld[BIT_POWER_OFF]; // [R4]
        cmpCtrl[BIT_BANDGAP_SEL] <= wDataHeld[BIT_BANDGAP_SEL]; // [R6]
        cmpCtrl[BIT_IRQ_EN] <= wDataHeld[BIT_IRQ_EN]; // [R9]
        cmpCtrl[BIT_CAPTURE_ROUTE] <= wDataHeld[BIT_CAPTURE_ROUTE]; // [R12]
        cmpCtrl[BIT_MODE_LO +: 2] <= wDataHeld[BIT_MODE_LO +: 2]; // [R14]
      end
    end
  end

  // Sticky flag: a new event wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      compareEventFlag <= 1'b0;
    end else if (eventHit) begin
      compareEventFlag <= 1'b1; // [R8]
    end else if (irqVectorAck || clearFlagWrite) begin
      compareEventFlag <= 1'b0; // [R10] [R11]
    end
  end

  assign irqRequest = compareEventFlag && cmpCtrl[BIT_IRQ_EN] && globalIrqEnable; // [R9]

  // Capture route is a plain gate so no path exists when disabled
  assign captureInput = captureRouteEnable && compareResult; // [R12] [R13]

  // Pin inputs
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pinSync1 <= 2'h0;
      pinSync2 <= 2'h0;
    end else begin
      pinSync1 <= pinRaw;
      pinSync2 <= pinSync1;
    end
  end

  assign inputBufferEnable = ~pinDisable[1:0]; // [R16]
  assign portPinIn = pinSync2 & ~pinDisable[1:0]; // [R16]

  // Read path
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_CONV_CTRL_B: s_axi_rdata <= {24'h000000, convCtrlB};
        OFS_CMP_CTRL_STATUS: begin
          s_axi_rdata <= {24'h000000, cmpCtrl[7:6], compareResult, compareEventFlag,
                          cmpCtrl[3:0]}; // [R7]
        end
        OFS_PIN_INPUT_DISABLE: s_axi_rdata <= {24'h000000, pinDisable};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  property p_resultLatency;
    compareResult == ($past(compareRaw, 2) && !$past(comparatorPowerOff, 2) &&
      !$past(comparatorPowerOff));
  endproperty
  a_resultLatency: assert property (p_resultLatency) // [R7]
    else $error("result not two clocks behind comparator");

  property p_powerOffLow;
    comparatorPowerOff [*3] |-> !compareResult;
  endproperty
  a_powerOffLow: assert property (p_powerOffLow) // [R1]
    else $error("result high while comparator off");

  property p_flagSet;
    eventHit |=> compareEventFlag;
  endproperty
  a_flagSet: assert property (p_flagSet) // [R8]
    else $error("event did not set flag");

  property p_risingOnly;
    $rose(compareEventFlag) && $past(eventMode == ACC_MODE_RISING) |->
      $past(compareResult);
  endproperty
  a_risingOnly: assert property (p_risingOnly) // [R14]
    else $error("flag set by non-rising edge in rising mode");

  property p_fallingOnly;
    $rose(compareEventFlag) && $past(eventMode == ACC_MODE_FALLING) |->
      !$past(compareResult);
  endproperty
  a_fallingOnly: assert property (p_fallingOnly) // [R14]
    else $error("flag set by non-falling edge in falling mode");

  property p_edgeSource;
    $rose(compareEventFlag) |-> $past(prevResult != compareResult);
  endproperty
  a_edgeSource: assert property (p_edgeSource) // [R20]
    else $error("flag set without a change of result");

  property p_reservedNoEvent;
    (eventMode == ACC_MODE_RESERVED) && !compareEventFlag |=> !compareEventFlag;
  endproperty
  a_reservedNoEvent: assert property (p_reservedNoEvent) // [R14]
    else $error("flag set in reserved mode");

  property p_irqGate;
    irqRequest |-> compareEventFlag && cmpCtrl[BIT_IRQ_EN] && globalIrqEnable;
  endproperty
  a_irqGate: assert property (p_irqGate) // [R9]
    else $error("interrupt requested without all enables");

  property p_vectorClear;
    irqVectorAck && !eventHit |=> !compareEventFlag;
  endproperty
  a_vectorClear: assert property (p_vectorClear) // [R10]
    else $error("vector did not clear flag");

  sequence s_clearWrite;
    wrCmp && wDataHeld[BIT_EVENT_FLAG] && !eventHit;
  endsequence
  sequence s_keepWrite;
    wrCmp && !wDataHeld[BIT_EVENT_FLAG] && !irqVectorAck && compareEventFlag;
  endsequence

  property p_writeOneClears;
    s_clearWrite |=> !compareEventFlag;
  endproperty
  a_writeOneClears: assert property (p_writeOneClears) // [R11]
    else $error("write one did not clear flag");

  property p_writeZeroKeeps;
    s_keepWrite |=> compareEventFlag;
  endproperty
  a_writeZeroKeeps: assert property (p_writeZeroKeeps) // [R11]
    else $error("write zero cleared flag");

  property p_captureRoute;
    captureInput == (captureRouteEnable && compareResult);
  endproperty
  a_captureRoute: assert property (p_captureRoute) // [R12]
    else $error("capture input does not follow result");

  property p_captureOff;
    !captureRouteEnable |-> !captureInput;
  endproperty
  a_captureOff: assert property (p_captureOff) // [R13]
    else $error("capture input active while route off");

  property p_negChannel;
    convCtrlB[BIT_MUX_NEG_EN] && !converterEnable |-> negUseChannel &&
      negChannel == channelSelect;
  endproperty
  a_negChannel: assert property (p_negChannel) // [R2]
    else $error("channel not used as negative input");

  property p_negPin;
    !convCtrlB[BIT_MUX_NEG_EN] || converterEnable |-> !negUseChannel;
  endproperty
  a_negPin: assert property (p_negPin) // [R3]
    else $error("channel used while pin required");

  property p_pinMask;
    pinDisable[0] |-> !portPinIn[0] && !inputBufferEnable[0];
  endproperty
  a_pinMask: assert property (p_pinMask) // [R16]
    else $error("disabled pin reads one");

  sequence s_powerOffWrite;
    wrCmp && wDataHeld[BIT_POWER_OFF];
  endsequence
  property p_powerOffWrite;
    s_powerOffWrite |=> comparatorPowerOff && s_axi_bvalid;
  endproperty
  a_powerOffWrite: assert property (p_powerOffWrite) // [R4]
    else $error("power-off write not applied");

endmodule : acc_analog_comparator_control

// ### acc_analog_comparator_control_tb.sv
// Self-checking testbench of the analog comparator control block
`timescale 1ns/1ps
module acc_analog_comparator_control_tb;
  import acc_pkg::*;
  logic mclk, reset_n, awV, wV, bRdy, arV, rRdy, awR, wR, bV, arR, rV, raw, pOff, bgS, useCh;
  logic convEn, gIe, vecAck, cRes, cFlag, irq, capEn, capIn;
  logic [3:0] awA, arA, wStb;
  logic [31:0] wD, rD, rdV;
  logic [1:0] bR, rR, rsp, pinRaw, bufEn, pinIn;
  logic [2:0] chSel, negCh;
  logic [7:0] posV, negV, bgV;
  logic [63:0] chanV;
  int mismatches, totalChecks;
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  acc_analog_comparator_control dut_u (.mclk(mclk), .reset_n(reset_n),
    .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD),
    .s_axi_wstrb(wStb), .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bR),
    .s_axi_bvalid(bV), .s_axi_bready(bRdy), .s_axi_araddr(arA), .s_axi_arvalid(arV),
    .s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rR), .s_axi_rvalid(rV),
    .s_axi_rready(rRdy), .compareRaw(raw), .converterEnable(convEn), .channelSelect(chSel),
    .globalIrqEnable(gIe), .irqVectorAck(vecAck), .pinRaw(pinRaw), .comparatorPowerOff(pOff),
    .bandgapPositiveSelect(bgS), .negUseChannel(useCh), .negChannel(negCh),
    .compareResult(cRes), .compareEventFlag(cFlag), .irqRequest(irq),
    .captureRouteEnable(capEn), .captureInput(capIn), .inputBufferEnable(bufEn),
    .portPinIn(pinIn));
  acc_analog_model model_u (.powerOff(pOff), .bgSel(bgS), .useChan(useCh), .chan(negCh),
    .posV(posV), .negV(negV), .bgV(bgV), .chanV(chanV), .raw(raw));
  task automatic summarize;
    $display("Checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic guard(input int n);
    if (n > 50) begin
      mismatches++;
      $display("[FAIL] bus handshake expected answer seen none");
      summarize();
    end
  endtask : guard
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick
  task automatic setV(input logic [7:0] p, input logic [7:0] n);
    @(posedge mclk);
    posV <= p;
    negV <= n;
  endtask : setV
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int n;
    logic ah, wh, bh;
    @(posedge mclk);
    awA <= a;
    wD <= {24'h000000, d};
    awV <= 1'b1;
    wV <= 1'b1;
    bRdy <= 1'b1;
    bh = 1'b0;
    n = 0;
    while (!bh) begin
      @(negedge mclk);
      ah = awV && awR;
      wh = wV && wR;
      bh = bV && bRdy;
      rsp = bR;
      n++;
      guard(n);
      @(posedge mclk);
      if (ah) awV <= 1'b0;
      if (wh) wV <= 1'b0;
      if (bh) bRdy <= 1'b0;
    end
    @(negedge mclk);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    int n;
    logic ah, rh;
    @(posedge mclk);
    arA <= a;
    arV <= 1'b1;
    rRdy <= 1'b1;
    rh = 1'b0;
    n = 0;
    while (!rh) begin
      @(negedge mclk);
      ah = arV && arR;
      rh = rV && rRdy;
      rdV = rD;
      rsp = rR;
      n++;
      guard(n);
      @(posedge mclk);
      if (ah) arV <= 1'b0;
      if (rh) rRdy <= 1'b0;
    end
    @(negedge mclk);
  endtask : rd
  task automatic t_regs;
    rd(OFS_CONV_CTRL_B);
    chk("conv ctrl b reset", {24'h000000, RST_CONV_CTRL_B}, rdV);
    rd(OFS_CMP_CTRL_STATUS);
    chk("cmp ctrl status reset", {24'h000000, RST_CMP_CTRL_STATUS}, rdV);
    rd(OFS_PIN_INPUT_DISABLE);
    chk("pin disable reset", {24'h000000, RST_PIN_INPUT_DISABLE}, rdV);
    rd(4'hC);
    chk("unmapped read resp", RESP_SLVERR, rsp);
    wr(4'hC, 8'hFF);
    chk("unmapped write resp", RESP_SLVERR, rsp);
  endtask : t_regs
  task automatic t_mux;
    wr(OFS_CONV_CTRL_B, 8'h40);
    setV(8'h80, 8'h20);
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      chSel <= 3'(k);
      convEn <= 1'b0;
      chanV <= 64'h1010101010101010 | (64'h80 << (k * 8));
      tick(3);
      chk("channel in use", 1, useCh);
      chk("channel number", k, negCh);
      chk("result vs channel", 0, cRes);
      @(posedge mclk);
      convEn <= 1'b1;
      tick(3);
      chk("pin while converter on", 0, useCh);
      chk("result vs pin", 1, cRes);
    end
    wr(OFS_CONV_CTRL_B, 8'h00);
    @(posedge mclk);
    convEn <= 1'b0;
    tick(1);
    chk("pin while mux off", 0, useCh);
  endtask : t_mux
  task automatic t_sync;
    setV(8'h10, 8'h20);
    tick(3);
    setV(8'h30, 8'h20);
    tick(2);
    chk("result one edge", 0, cRes);
    tick(1);
    chk("result two edges", 1, cRes);
    wr(OFS_CMP_CTRL_STATUS, 8'h40);
    tick(3);
    chk("bandgap select", 1, bgS);
    chk("result vs bandgap", 0, cRes);
    wr(OFS_CMP_CTRL_STATUS, 8'h00);
  endtask : t_sync
  task automatic t_events;
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 2'((i * 3) % 4);
      setV(8'h10, 8'h20);
      tick(3);
      wr(OFS_CMP_CTRL_STATUS, 8'h10 | m);
      chk("flag cleared", 0, cFlag);
      setV(8'h30, 8'h20);
      tick(4);
      chk("flag on rise", m == 2'b00 || m == 2'b11, cFlag);
      wr(OFS_CMP_CTRL_STATUS, 8'h10 | m);
      setV(8'h10, 8'h20);
      tick(4);
      chk("flag on fall", m == 2'b00 || m == 2'b10, cFlag);
    end
  endtask : t_events
  task automatic t_irq;
    wr(OFS_CMP_CTRL_STATUS, 8'h10);
    setV(8'h30, 8'h20);
    tick(4);
    wr(OFS_CMP_CTRL_STATUS, 8'h08);
    chk("flag kept on zero write", 1, cFlag);
    chk("request without global", 0, irq);
    @(posedge mclk);
    gIe <= 1'b1;
    tick(1);
    chk("request all enabled", 1, irq);
    wr(OFS_CMP_CTRL_STATUS, 8'h00);
    chk("request enable off", 0, irq);
    wr(OFS_CMP_CTRL_STATUS, 8'h08);
    @(posedge mclk);
    vecAck <= 1'b1;
    @(posedge mclk);
    vecAck <= 1'b0;
    tick(1);
    chk("flag after vector", 0, cFlag);
    chk("request after vector", 0, irq);
  endtask : t_irq
  task automatic t_route;
    wr(OFS_CMP_CTRL_STATUS, 8'h04);
    chk("route on, high", 1, capIn);
    chk("route enable on", 1, capEn);
    setV(8'h10, 8'h20);
    tick(3);
    chk("route on, low", 0, capIn);
    setV(8'h30, 8'h20);
    tick(3);
    wr(OFS_CMP_CTRL_STATUS, 8'h00);
    chk("route off", 0, capIn);
    chk("route enable off", 0, capEn);
  endtask : t_route
  task automatic t_pins;
    @(posedge mclk);
    pinRaw <= 2'b11;
    wr(OFS_PIN_INPUT_DISABLE, 8'h01);
    tick(3);
    chk("port bits, pos off", 2'b10, pinIn);
    chk("buffers, pos off", 2'b10, bufEn);
    wr(OFS_PIN_INPUT_DISABLE, 8'h02);
    chk("disable write resp", RESP_OKAY, rsp);
    tick(1);
    chk("port bits, neg off", 2'b01, pinIn);
    rd(OFS_PIN_INPUT_DISABLE);
    chk("disable readback", 32'h00000002, rdV);
    chk("disable read resp", RESP_OKAY, rsp);
  endtask : t_pins
  task automatic t_power;
    wr(OFS_CMP_CTRL_STATUS, 8'hA0);
    chk("power off output", 1, pOff);
    tick(3);
    chk("result when off", 0, cRes);
    rd(OFS_CMP_CTRL_STATUS);
    chk("status when off", 32'h00000080, rdV & 32'hFFFFFFEF);
  endtask : t_power
  initial begin
    {reset_n, awV, wV, bRdy, arV, rRdy, convEn, gIe, vecAck} = '0;
    {awA, arA, wD, chSel, pinRaw, posV, bgV} = '0;
    wStb = 4'hF;
    negV = 8'h80;
    bgV = 8'h05;
    chanV = '0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs();
    t_mux();
    t_sync();
    t_events();
    t_irq();
    t_route();
    t_pins();
    t_power();
    summarize();
  end
endmodule : acc_analog_comparator_control_tb

// ### acc_analog_model.sv
// Behavioural model of the comparator core and its input multiplexers
`timescale 1ns/1ps
module acc_analog_model (
  input wire logic powerOff, // Comparator unpowered
  input wire logic bgSel, // Bandgap as positive input
  input wire logic useChan, // Channel mux as negative input
  input wire logic [2:0] chan, // Channel for negative input
  input wire logic [7:0] posV, // Positive pin level
  input wire logic [7:0] negV, // Negative pin level
  input wire logic [7:0] bgV, // Bandgap level
  input wire logic [63:0] chanV, // Eight channel levels
  output logic raw // Raw comparator output
);
  logic [7:0] plusIn;
  logic [7:0] minusIn;
  assign plusIn = bgSel ? bgV : posV;
  assign minusIn = useChan ? chanV[chan*8 +: 8] : negV;
  assign raw = !powerOff && (plusIn > minusIn);
endmodule : acc_analog_model

// ### acc_pkg.sv
// Constants and register map of the analog comparator control block
// Overview of operation
// [R1] Result is high when positive input exceeds negative input, else low.
// [R2] Mux enable set and converter off: channel select picks channel 0..7 as negative.
// [R3] Mux enable clear or converter on: dedicated negative pin is used.
// [R4] Power-off bit set keeps comparator unpowered; writable any time.
// [R5] Software clears interrupt enable before changing the power-off bit.
// [R6] Bandgap select picks bandgap as positive input, else positive pin.
// [R7] Raw result is synchronised before reading, latency one to two clocks.
// [R8] Event flag sets on the edge type chosen by event mode.
// [R9] Interrupt requested only when flag, enable and global enable are set.
// [R10] Executing the comparator interrupt vector clears the event flag.
// [R11] Writing one to the flag clears it; writing zero leaves it.
// [R12] Capture route enable feeds the result to the timer capture front end.
// [R13] Capture route disabled keeps the result away from timer capture.
// [R14] Mode 00 toggle, 10 falling, 11 rising, 01 reserved.
// [R15] Software clears interrupt enable before changing event mode.
// [R16] Buffer disable bit turns off pin buffer; port input reads zero.
// [R17] Software should disable buffers on analog-only comparator pins.
// [R18] Software keeps converter power gate clear when borrowing the channel mux.
// [R19] Software sets timer capture interrupt enable for capture interrupts.
// [R20] Events come from comparing the result with its value one clock before.
package acc_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CONV_CTRL_B = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CMP_CTRL_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_PIN_INPUT_DISABLE = 4'h8;
  localparam logic [7:0] RST_CONV_CTRL_B = 8'h00;
  localparam logic [7:0] RST_CMP_CTRL_STATUS = 8'h00;
  localparam logic [7:0] RST_PIN_INPUT_DISABLE = 8'h00;
  // Field positions
  localparam int BIT_MUX_NEG_EN = 6;
  localparam int BIT_POWER_OFF = 7;
  localparam int BIT_BANDGAP_SEL = 6;
  localparam int BIT_RESULT = 5;
  localparam int BIT_EVENT_FLAG = 4;
  localparam int BIT_IRQ_EN = 3;
  localparam int BIT_CAPTURE_ROUTE = 2;
  localparam int BIT_MODE_LO = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE = 2'b00,
    ACC_MODE_RESERVED = 2'b01,
    ACC_MODE_FALLING = 2'b10,
    ACC_MODE_RISING = 2'b11
  } acc_mode_t;
endpackage : acc_pkg
